// ---- ulsc_pkg.sv ----
// package: register map, field positions and timing constants for the line status/control block
package ulsc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS_TWO = 8'h00; // line_status_two
  localparam logic [7:0] ADDR_CONTROL_THREE = 8'h04; // line_control_three
  localparam logic [7:0] ADDR_AUX_CONTROL = 8'h08; // mode and irq enable bits
  localparam logic [7:0] ADDR_AUX_STATUS = 8'h0C; // receive-side flags, read only

  // ----------------------------------------------------------------
  // line_status_two fields
  // ----------------------------------------------------------------
  localparam int S2_BRK_FLAG = 7;
  localparam int S2_EDGE_FLAG = 6;
  localparam int S2_RX_FLIP = 4;
  localparam int S2_WAKE_IDLE = 3;
  localparam int S2_LONG_BRK = 2;
  localparam int S2_BRK_DET_EN = 1;
  localparam int S2_RX_ACTIVE = 0;
  localparam logic [7:0] S2_RESET = 8'h00;

  // ----------------------------------------------------------------
  // line_control_three fields
  // ----------------------------------------------------------------
  localparam int C3_RX_NINTH = 7;
  localparam int C3_TX_NINTH = 6;
  localparam int C3_PIN_DIR = 5;
  localparam int C3_TX_FLIP = 4;
  localparam int C3_OVR_IE = 3;
  localparam int C3_NOISE_IE = 2;
  localparam int C3_FRAME_IE = 1;
  localparam int C3_PARITY_IE = 0;
  localparam logic [7:0] C3_RESET = 8'h00;

  // ----------------------------------------------------------------
  // aux control fields
  // ----------------------------------------------------------------
  localparam int AX_NINE_BIT = 0;
  localparam int AX_LOOP = 1;
  localparam int AX_RX_SRC = 2;
  localparam int AX_STANDBY = 3;
  localparam int AX_BRK_IE = 4;
  localparam int AX_EDGE_IE = 5;
  localparam logic [7:0] AX_RESET = 8'h00;

  // ----------------------------------------------------------------
  // timing: bit times in a frame
  // ----------------------------------------------------------------
  localparam logic [3:0] FRAME_BITS_8 = 4'hA; // 10 bit times
  localparam logic [3:0] BRK_SHORT = 4'hA; // 10 bit times
  localparam logic [3:0] BRK_LONG = 4'hD; // 13 bit times
  localparam logic [3:0] DET_SHORT = 4'hA; // 10 bit times
  localparam logic [3:0] DET_LONG = 4'hB; // 11 bit times

  // receive-side error flags from the main receiver
  typedef struct packed {
    logic overrun;
    logic noise;
    logic framing;
    logic parity;
  } ulsc_err_type;

endpackage : ulsc_pkg

// ---- ulsc_top.sv ----
// module: secondary status/control logic of the serial line, with an AHB-Lite slave
//
// Contract
// - break seen with detect enabled sets bit 7
// - active receive edge sets bit 6
// - receive inversion applies to whole frame
// - standby idle sets idle only if enabled
// - long break select lengthens transmitted break
// - framing detection ignores break length select
// - detect enable raises break threshold one bit
// - detect enable blocks framing and full flags
// - active flag set on start, cleared idle
// - received ninth bit read at bit 7
// - ninth transmit bit joins data on write
// - single-wire direction bit drives transmit pin
// - transmit inversion flips serial output
// - overrun enable gates overrun request
// - noise enable gates noise request
// - framing enable gates framing request
// - parity enable gates parity request
// - transmit inversion covers whole frame
// - frame is 10 or 11 bits
//
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module ulsc_top (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [7:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // serial pins
  input wire logic i_rx_pin,
  input wire logic i_tx_pin_in,
  output logic o_tx_pin,
  output logic o_tx_pin_oe,
  // from the main shifters (same clock)
  input wire logic i_bit_tick,
  input wire logic i_tx_raw,
  input wire logic i_tx_busy,
  input wire logic i_rx_start,
  input wire logic i_rx_idle,
  input wire logic i_rx_done,
  input wire logic i_rx_bit9,
  input wire logic i_rx_frame_err,
  input wire ulsc_pkg::ulsc_err_type i_err,
  input wire logic i_data_write,
  input wire logic [7:0] i_data_wr_byte,
  // to the main shifters
  output logic o_rx_line,
  output logic [8:0] o_tx_word,
  output logic o_tx_load,
  output logic [3:0] o_brk_len,
  output logic o_nine_bit,
  output logic o_rx_idle_set,
  output logic o_rx_full_set,
  output logic o_frame_err_set,
  output logic o_irq
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // software-visible registers
  logic [7:0] s2_q; // line_status_two
  logic [7:0] c3_q; // line_control_three
  logic [7:0] ax_q; // aux control
  // internal state
  logic rx_s1_q, rx_s2_q, rx_s3_q; // receive pin synchroniser and history
  logic [3:0] low_cnt_q; // bit times of low line seen
  logic brk_armed_q; // a break counts once per low stretch
  // transmit hand-off
  logic [8:0] tx_word_q; // word handed to the shifter
  logic tx_load_q;
  // read mux output, combinational
  logic [31:0] rdata_q;

  // bus address phase capture
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] addr_q;
  // valid request, sampled per edge
  logic take;
  assign take = i_hsel && i_hready && i_htrans[1];

  // ----------------------------------------------------------------
  // bus address phase
  // ----------------------------------------------------------------
  // capture one access; the slave always answers in the next cycle
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_pend_q <= take && i_hwrite;
      rd_pend_q <= take && !i_hwrite;
      if (take) begin
        addr_q <= i_haddr;
      end
    end
  end

  // registers never stretch a phase
  assign o_hreadyout = 1'b1; // zero wait states
  assign o_hresp = 1'b0; // always okay

  // write strobes, one per writable register
  logic wr_s2, wr_c3, wr_ax;
  assign wr_s2 = wr_pend_q && (addr_q == ulsc_pkg::ADDR_STATUS_TWO);
  assign wr_c3 = wr_pend_q && (addr_q == ulsc_pkg::ADDR_CONTROL_THREE);
  assign wr_ax = wr_pend_q && (addr_q == ulsc_pkg::ADDR_AUX_CONTROL);

  // ----------------------------------------------------------------
  // receive pin conditioning
  // ----------------------------------------------------------------
  // single wire: listen on tx pin
  logic loop_mode, single_wire, rx_src, rx_line;
  assign loop_mode = ax_q[ulsc_pkg::AX_LOOP];
  assign rx_src = ax_q[ulsc_pkg::AX_RX_SRC];
  assign single_wire = loop_mode && rx_src;

  // two flops before use; the third is history for edge detect
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      // reset to idle, no false edge
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_s3_q <= 1'b1;
    end else begin
      rx_s1_q <= single_wire ? i_tx_pin_in : i_rx_pin;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
    end
  end

  // inversion applied once here so every frame part sees it
  assign rx_line = rx_s2_q ^ s2_q[ulsc_pkg::S2_RX_FLIP];
  assign o_rx_line = rx_line;

  // flipping the bit alone is no edge
  logic edge_ev;
  // active edge is a falling edge of the logical line, whatever the inversion
  assign edge_ev = (rx_s3_q ^ s2_q[ulsc_pkg::S2_RX_FLIP]) && !rx_line;

  // ----------------------------------------------------------------
  // break detection
  // ----------------------------------------------------------------
  // mode bits used below
  logic nine, det_en;
  logic [3:0] det_thr;
  logic brk_ev;
  assign nine = ax_q[ulsc_pkg::AX_NINE_BIT];
  assign det_en = s2_q[ulsc_pkg::S2_BRK_DET_EN];
  // threshold in bit times, one more in nine-bit frames
  assign det_thr = (det_en ? ulsc_pkg::DET_LONG : ulsc_pkg::DET_SHORT)
                   + {3'h0, nine};

  // saturates at 15 bit times
  // counts low bit times; cleared on any high sample
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      low_cnt_q <= 4'h0;
      brk_armed_q <= 1'b1;
    end else if (rx_line) begin
      low_cnt_q <= 4'h0;
      brk_armed_q <= 1'b1;
    end else if (i_bit_tick && low_cnt_q != 4'hF) begin
      low_cnt_q <= low_cnt_q + 4'h1;
    end else if (brk_ev) begin
      brk_armed_q <= 1'b0;
    end
  end

  // once per low stretch
  assign brk_ev = det_en && brk_armed_q && (low_cnt_q >= det_thr);

  // ----------------------------------------------------------------
  // line_status_two
  // ----------------------------------------------------------------
  // flags: set wins over a write-one clear, a zero write keeps the flag
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s2_q <= ulsc_pkg::S2_RESET;
    end else begin
      // break seen flag
      if (brk_ev) begin
        s2_q[ulsc_pkg::S2_BRK_FLAG] <= 1'b1;
      end else if (wr_s2 && i_hwdata[ulsc_pkg::S2_BRK_FLAG]) begin
        s2_q[ulsc_pkg::S2_BRK_FLAG] <= 1'b0;
      end
      // receive edge flag
      if (edge_ev) begin
        s2_q[ulsc_pkg::S2_EDGE_FLAG] <= 1'b1;
      end else if (wr_s2 && i_hwdata[ulsc_pkg::S2_EDGE_FLAG]) begin
        s2_q[ulsc_pkg::S2_EDGE_FLAG] <= 1'b0;
      end
      // plain control bits
      if (wr_s2) begin
        s2_q[ulsc_pkg::S2_RX_FLIP] <= i_hwdata[ulsc_pkg::S2_RX_FLIP];
        s2_q[ulsc_pkg::S2_WAKE_IDLE] <= i_hwdata[ulsc_pkg::S2_WAKE_IDLE];
        s2_q[ulsc_pkg::S2_LONG_BRK] <= i_hwdata[ulsc_pkg::S2_LONG_BRK];
        s2_q[ulsc_pkg::S2_BRK_DET_EN] <= i_hwdata[ulsc_pkg::S2_BRK_DET_EN];
      end
      // start wins over idle when both arrive together
      if (i_rx_start) begin
        s2_q[ulsc_pkg::S2_RX_ACTIVE] <= 1'b1;
      end else if (i_rx_idle) begin
        s2_q[ulsc_pkg::S2_RX_ACTIVE] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // receiver flag gating
  // ----------------------------------------------------------------
  // receiver owns these flags
  logic standby;
  assign standby = ax_q[ulsc_pkg::AX_STANDBY];
  // idle from a waking character only counts when asked for
  assign o_rx_idle_set = i_rx_idle && (!standby || s2_q[ulsc_pkg::S2_WAKE_IDLE]);
  // break-length select plays no part in framing checks
  assign o_rx_full_set = i_rx_done && !det_en;
  assign o_frame_err_set = i_rx_done && i_rx_frame_err && !det_en;

  // ----------------------------------------------------------------
  // line_control_three and aux control
  // ----------------------------------------------------------------
  // received ninth bit latched with the character, like the data buffer
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      c3_q <= ulsc_pkg::C3_RESET;
    end else begin
      // bit 7 is read only
      if (o_rx_full_set && nine) begin
        c3_q[ulsc_pkg::C3_RX_NINTH] <= i_rx_bit9;
      end
      // bits 6:0 from software
      if (wr_c3) begin
        c3_q[6:0] <= i_hwdata[6:0]; // ninth tx bit persists until rewritten
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      // all modes off after reset
      ax_q <= ulsc_pkg::AX_RESET;
    end else if (wr_ax) begin
      // bits 7:6 read zero
      ax_q <= {2'h0, i_hwdata[5:0]};
    end
  end

  // ----------------------------------------------------------------
  // transmit word and break length
  // ----------------------------------------------------------------
  // a data write takes the current ninth bit with it
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_word_q <= 9'h000;
      tx_load_q <= 1'b0;
    end else begin
      // load follows write by one
      tx_load_q <= i_data_write;
      if (i_data_write) begin
        tx_word_q <= {nine & c3_q[ulsc_pkg::C3_TX_NINTH], i_data_wr_byte};
      end
    end
  end
  assign o_tx_word = tx_word_q;
  assign o_tx_load = tx_load_q;
  // frame length for the shifter
  assign o_nine_bit = nine;

  // +1 bit time in nine-bit frames
  assign o_brk_len = (s2_q[ulsc_pkg::S2_LONG_BRK] ? ulsc_pkg::BRK_LONG
                      : ulsc_pkg::BRK_SHORT) + {3'h0, nine};

  // ----------------------------------------------------------------
  // transmit pin
  // ----------------------------------------------------------------
  // pin drive and polarity
  // inversion sits after the shifter so break and idle flip as well
  assign o_tx_pin = i_tx_raw ^ c3_q[ulsc_pkg::C3_TX_FLIP];
  // single-wire: the direction bit alone decides the drive
  assign o_tx_pin_oe = single_wire ? c3_q[ulsc_pkg::C3_PIN_DIR] : 1'b1;

  // ----------------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------------
  // level, follows the flags
  // one shared line: poll to find why
  assign o_irq = (i_err.overrun && c3_q[ulsc_pkg::C3_OVR_IE])
               || (i_err.noise && c3_q[ulsc_pkg::C3_NOISE_IE])
               || (i_err.framing && c3_q[ulsc_pkg::C3_FRAME_IE])
               || (i_err.parity && c3_q[ulsc_pkg::C3_PARITY_IE])
               || (s2_q[ulsc_pkg::S2_BRK_FLAG] && ax_q[ulsc_pkg::AX_BRK_IE])
               || (s2_q[ulsc_pkg::S2_EDGE_FLAG] && ax_q[ulsc_pkg::AX_EDGE_IE]);

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // unmapped addresses read zero
  always_comb begin
    unique case (addr_q)
      ulsc_pkg::ADDR_STATUS_TWO: rdata_q = {24'h0, s2_q[7:6], 1'b0, s2_q[4:0]};
      ulsc_pkg::ADDR_CONTROL_THREE: rdata_q = {24'h0, c3_q};
      ulsc_pkg::ADDR_AUX_CONTROL: rdata_q = {24'h0, ax_q};
      ulsc_pkg::ADDR_AUX_STATUS: rdata_q = {28'h0, i_err};
      default: rdata_q = 32'h0;
    endcase
  end
  // zero outside a read data phase
  assign o_hrdata = rd_pend_q ? rdata_q : 32'h0;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // flags and gating
  a_brk_sets_flag: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    brk_ev |=> s2_q[ulsc_pkg::S2_BRK_FLAG])
    else $error("break flag not set");

  a_edge_set_wins: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (edge_ev && wr_s2) |=> s2_q[ulsc_pkg::S2_EDGE_FLAG])
    else $error("edge flag lost");

  a_zero_keeps_flag: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (wr_s2 && !i_hwdata[7] && s2_q[7]) |=> s2_q[7])
    else $error("flag cleared by zero");

  a_full_blocked: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    det_en |-> !o_rx_full_set && !o_frame_err_set)
    else $error("flag set while detecting");

  a_active_idle: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_rx_idle && !i_rx_start) |=> !s2_q[0])
    else $error("active flag kept at idle");

  a_standby_idle: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (standby && !s2_q[3]) |-> !o_rx_idle_set)
    else $error("idle set in standby");

  // transmit side
  a_tx_ninth_load: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_data_write && nine) |=> o_tx_load && o_tx_word[8] == $past(c3_q[6]))
    else $error("ninth bit not loaded");

  a_brk_len_long: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (s2_q[2] && nine) |-> o_brk_len == 4'hE)
    else $error("long break length wrong");

  // request enables
  a_irq_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (c3_q[3:0] == 4'h0 && ax_q[5:4] == 2'h0) |-> !o_irq)
    else $error("irq without enable");

  // scenarios worth seeing
  c_break_seen: cover property (@(posedge i_ref_clk) disable iff (!i_rst_b) brk_ev);
  c_edge_seen: cover property (@(posedge i_ref_clk) disable iff (!i_rst_b) edge_ev);
  c_tx_load: cover property (@(posedge i_ref_clk) disable iff (!i_rst_b) o_tx_load && nine);

endmodule : ulsc_top

// ---- ulsc_remote_node.sv ----
// remote serial node model: drives the receive pin and shares the single-wire pin
`timescale 1ns/100ps
module ulsc_remote_node #(
  parameter int BIT_CYCLES = 4 // clock cycles per bit time, matches the bench tick
) (
  input wire logic i_ref_clk,
  input wire logic i_tx_pin,
  input wire logic i_tx_pin_oe,
  output logic o_rx_pin,
  output logic o_tx_wire
);
  // ------------------------------------------------------------
  // line state
  // ------------------------------------------------------------
  logic rx_q = 1'b1; // a quiet line rests high
  assign o_rx_pin = rx_q;
  // shared pin has a pull-up, so a released pin reads high, never a stale value
  assign o_tx_wire = i_tx_pin_oe ? i_tx_pin : 1'b1;

  // ------------------------------------------------------------
  // stimulus tasks
  // ------------------------------------------------------------
  // move the line to a level and let the synchroniser catch up
  task automatic set_rx(input logic lvl);
    @(posedge i_ref_clk);
    rx_q <= lvl;
    repeat (6) @(posedge i_ref_clk);
  endtask : set_rx

  // fall now, exact timing
  task automatic drop_rx();
    rx_q <= 1'b0;
  endtask : drop_rx

  // hold the line at a level for whole bit times, then return to idle
  task automatic hold_rx(input logic lvl, input int bits);
    @(posedge i_ref_clk);
    rx_q <= lvl;
    repeat (bits * BIT_CYCLES) @(posedge i_ref_clk);
    rx_q <= 1'b1;
    repeat (8) @(posedge i_ref_clk);
  endtask : hold_rx
endmodule : ulsc_remote_node

// ---- test_uart_lin_status_ctrl_ext.sv ----
// testbench: registers, flags, break logic and pin controls of the line status block
`timescale 1ns/100ps
module test_uart_lin_status_ctrl_ext;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam logic [7:0] A_S2 = ulsc_pkg::ADDR_STATUS_TWO;
  localparam logic [7:0] A_C3 = ulsc_pkg::ADDR_CONTROL_THREE;
  localparam logic [7:0] A_AX = ulsc_pkg::ADDR_AUX_CONTROL;
  logic clk, rst_b, hsel, hwrite, hready, hresp, rx_pin, tx_wire, tx_pin, tx_oe, tx_raw;
  logic [7:0] haddr, data_byte;
  logic [1:0] htrans;
  logic [1:0] tick_cnt = 2'h0; // divides the clock into bit times
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd_v;
  logic bit_tick = 1'b0;
  logic rx_start, rx_idle, rx_done, rx_bit9, rx_ferr, data_write;
  logic rx_line, tx_load, nine_bit, idle_set, full_set, ferr_set, irq;
  logic c_idle, c_full, c_ferr; // gated pulses captured mid-strobe
  logic [8:0] tx_word;
  logic [3:0] brk_len;
  ulsc_pkg::ulsc_err_type err;
  int miscompares = 0;
  int comparisons = 0;

  ulsc_top i_ulsc_top (
    .i_ref_clk(clk), .i_rst_b(rst_b), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_rx_pin(rx_pin),
    .i_tx_pin_in(tx_wire), .o_tx_pin(tx_pin), .o_tx_pin_oe(tx_oe), .i_bit_tick(bit_tick),
    .i_tx_raw(tx_raw), .i_tx_busy(tx_load), .i_rx_start(rx_start), .i_rx_idle(rx_idle),
    .i_rx_done(rx_done), .i_rx_bit9(rx_bit9), .i_rx_frame_err(rx_ferr), .i_err(err),
    .i_data_write(data_write), .i_data_wr_byte(data_byte), .o_rx_line(rx_line),
    .o_tx_word(tx_word), .o_tx_load(tx_load), .o_brk_len(brk_len), .o_nine_bit(nine_bit),
    .o_rx_idle_set(idle_set), .o_rx_full_set(full_set), .o_frame_err_set(ferr_set),
    .o_irq(irq)
  );

  ulsc_remote_node i_ulsc_remote_node (
    .i_ref_clk(clk), .i_tx_pin(tx_pin), .i_tx_pin_oe(tx_oe), .o_rx_pin(rx_pin),
    .o_tx_wire(tx_wire)
  );

  // clock and a bit tick every fourth cycle
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    tick_cnt <= tick_cnt + 2'h1;
    bit_tick <= (tick_cnt == 2'h3);
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // bounded wait for hready at a rising edge; a hang ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 16);
    if (hready !== 1'b1) begin
      miscompares++;
      close_out();
    end
  endtask : wait_ready

  // one single-word transfer; read data taken at the edge closing the data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd_v = hrdata;
    @(negedge clk); // let the register update land before anyone looks
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic chk_rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd_v);
    chk("okay response", 32'h0, {31'h0, hresp});
  endtask : chk_rd

  // one-cycle receiver strobe {start, idle, done}; gated outputs captured meanwhile
  task automatic strobe(input logic [2:0] s, input logic fe, input logic b9);
    @(posedge clk);
    {rx_start, rx_idle, rx_done} <= s;
    rx_ferr <= fe;
    rx_bit9 <= b9;
    @(negedge clk);
    {c_idle, c_full, c_ferr} = {idle_set, full_set, ferr_set};
    @(posedge clk);
    {rx_start, rx_idle, rx_done} <= 3'h0;
    @(negedge clk);
  endtask : strobe

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    chk_rd("status_two reset", A_S2, {24'h0, ulsc_pkg::S2_RESET});
    chk_rd("control_three reset", A_C3, {24'h0, ulsc_pkg::C3_RESET});
    chk_rd("aux reset", A_AX, {24'h0, ulsc_pkg::AX_RESET});
    chk_rd("unmapped read", 8'h10, 32'h0);
    wr(8'h10, 32'hFF);
    wr(A_S2, 32'hEF); // flags clear, active flag read only
    chk_rd("status_two writable", A_S2, 32'h0E);
    wr(A_C3, 32'hFF);
    chk_rd("control_three writable", A_C3, 32'h7F);
    wr(A_S2, 32'h0);
    wr(A_C3, 32'h0);
    $display("test registers done");
  endtask : t_regs

  task automatic t_edge();
    i_ulsc_remote_node.set_rx(1'b0);
    chk("line follows pin", 32'h0, {31'h0, rx_line});
    chk_rd("edge on pin fall", A_S2, 32'h40);
    wr(A_S2, 32'h0);
    chk_rd("edge kept on write 0", A_S2, 32'h40);
    wr(A_S2, 32'h40);
    chk_rd("edge cleared", A_S2, 32'h0);
    i_ulsc_remote_node.set_rx(1'b1);
    wr(A_S2, 32'h10); // flipping the line itself raises no edge
    repeat (6) @(posedge clk);
    wr(A_S2, 32'h50);
    chk("line inverted", 32'h0, {31'h0, rx_line});
    i_ulsc_remote_node.set_rx(1'b0);
    chk_rd("no edge on inverted fall", A_S2, 32'h10);
    i_ulsc_remote_node.set_rx(1'b1);
    chk_rd("edge on inverted rise", A_S2, 32'h50);
    wr(A_S2, 32'h40);
    @(posedge clk);
    i_ulsc_remote_node.drop_rx();
    wr(A_S2, 32'h40); // clear lands with the set
    chk_rd("edge set wins", A_S2, 32'h40);
    wr(A_S2, 32'h40);
    i_ulsc_remote_node.set_rx(1'b1);
    $display("test receive edge done");
  endtask : t_edge

  task automatic t_break();
    wr(A_S2, 32'h02);
    i_ulsc_remote_node.hold_rx(1'b0, 10);
    chk_rd("no break at 10 bits", A_S2, 32'h42);
    wr(A_S2, 32'h42);
    i_ulsc_remote_node.hold_rx(1'b0, 12);
    chk_rd("break at 12 bits", A_S2, 32'hC2);
    wr(A_S2, 32'hC2);
    chk_rd("break cleared", A_S2, 32'h02);
    strobe(3'h1, 1'b1, 1'b0);
    chk("full blocked", 32'h0, {31'h0, c_full});
    chk("framing blocked", 32'h0, {31'h0, c_ferr});
    wr(A_S2, 32'h0);
    strobe(3'h1, 1'b1, 1'b0);
    chk("full passes", 32'h1, {31'h0, c_full});
    chk("framing passes", 32'h1, {31'h0, c_ferr});
    $display("test break detect done");
  endtask : t_break

  task automatic t_brklen();
    for (int i = 0; i < 4; i++) begin
      wr(A_S2, i[1] ? 32'h04 : 32'h0);
      wr(A_AX, {31'h0, i[0]});
      chk("break length", (i[1] ? 32'hD : 32'hA) + i[0], {28'h0, brk_len});
      chk("nine bit mode", {31'h0, i[0]}, {31'h0, nine_bit});
      strobe(3'h1, 1'b1, 1'b0);
      chk("framing any length", 32'h1, {31'h0, c_ferr});
    end
    wr(A_S2, 32'h0);
    wr(A_AX, 32'h0);
    $display("test break length done");
  endtask : t_brklen

  task automatic t_irq();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      err <= ulsc_pkg::ulsc_err_type'(4'h1 << i);
      wr(A_C3, 32'h0);
      chk("request disabled", 32'h0, {31'h0, irq});
      wr(A_C3, 32'h1 << i);
      chk("request enabled", 32'h1, {31'h0, irq});
      wr(A_C3, 32'h1 << ((i + 1) % 4));
      chk("other enable", 32'h0, {31'h0, irq});
    end
    @(posedge clk);
    err <= ulsc_pkg::ulsc_err_type'(4'h0);
    wr(A_C3, 32'h0);
    i_ulsc_remote_node.set_rx(1'b0);
    chk("edge without enable", 32'h0, {31'h0, irq});
    wr(A_AX, 32'h20);
    chk("edge with enable", 32'h1, {31'h0, irq});
    wr(A_S2, 32'h40);
    chk("edge cleared request", 32'h0, {31'h0, irq});
    wr(A_AX, 32'h0);
    i_ulsc_remote_node.set_rx(1'b1);
    $display("test requests done");
  endtask : t_irq

  // software data write, then the load pulse one cycle later
  task automatic send(input logic [7:0] b, input logic [8:0] exp);
    @(posedge clk);
    data_write <= 1'b1;
    data_byte <= b;
    @(posedge clk);
    data_write <= 1'b0;
    @(negedge clk);
    chk("load pulse", 32'h1, {31'h0, tx_load});
    chk("shifter word", {23'h0, exp}, {23'h0, tx_word});
  endtask : send

  task automatic t_tx();
    wr(A_AX, 32'h01);
    wr(A_C3, 32'h40);
    send(8'hA5, 9'h1A5);
    send(8'h3C, 9'h13C);
    wr(A_C3, 32'h0);
    send(8'hA5, 9'h0A5);
    for (int i = 0; i < 4; i++) begin
      wr(A_C3, i[1] ? 32'h10 : 32'h0);
      @(posedge clk);
      tx_raw <= i[0];
      @(negedge clk);
      chk("transmit pin", {31'h0, i[0] ^ i[1]}, {31'h0, tx_pin});
    end
    wr(A_AX, 32'h06);
    wr(A_C3, 32'h0);
    chk("single wire input", 32'h0, {31'h0, tx_oe});
    chk("released wire high", 32'h1, {31'h0, tx_wire});
    wr(A_C3, 32'h20);
    chk("single wire output", 32'h1, {31'h0, tx_oe});
    wr(A_AX, 32'h0);
    wr(A_C3, 32'h0);
    chk("normal mode drives", 32'h1, {31'h0, tx_oe});
    $display("test transmit done");
  endtask : t_tx

  task automatic t_rxinfo();
    strobe(3'h4, 1'b0, 1'b0);
    chk_rd("active on start", A_S2, 32'h01);
    strobe(3'h2, 1'b0, 1'b0);
    chk_rd("inactive on idle", A_S2, 32'h0);
    wr(A_AX, 32'h01);
    strobe(3'h1, 1'b0, 1'b1);
    chk_rd("ninth bit one", A_C3, 32'h80);
    strobe(3'h1, 1'b0, 1'b0);
    chk_rd("ninth bit zero", A_C3, 32'h0);
    wr(A_AX, 32'h08);
    strobe(3'h2, 1'b0, 1'b0);
    chk("standby idle held", 32'h0, {31'h0, c_idle});
    wr(A_S2, 32'h08);
    strobe(3'h2, 1'b0, 1'b0);
    chk("standby idle set", 32'h1, {31'h0, c_idle});
    $display("test receive info done");
  endtask : t_rxinfo

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    {hsel, hwrite, tx_raw, rx_start, rx_idle, rx_done, rx_bit9, rx_ferr} = 8'h0;
    {haddr, data_byte, htrans, hsize, hwdata} = 53'h0;
    data_write = 1'b0;
    err = ulsc_pkg::ulsc_err_type'(4'h0);
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_edge();
    t_break();
    t_brklen();
    t_irq();
    t_tx();
    t_rxinfo();
    close_out();
  end
endmodule : test_uart_lin_status_ctrl_ext
